// *** logic/ictim_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Count execution in whole 250 ns clocks.
// - Time is clocks times period plus memory cycles times memory cycle time.
// - Charge base cost plus used mode increments.
// - Absolute value costs 5,2 or 5,3.
// - Serial output costs 4,2 plus one per bit.
// - Serial input 18,3 or 24,3 plus bits.
// - Extended op hardware 3,2+module, software 7,7.
module ictim_top
   import ictim_pkg::*;
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Instruction presented at fetch.
   input wire logic i_fetch,
   input wire ictim_pkg::ictim_instr_s i_instr,
   // Memory configuration.
   input wire logic i_ecc_mem,
   input wire logic i_map_en,
   // Results.
   output ictim_pkg::ictim_cost_s o_cost,
   output logic o_done,
   output logic o_cpu_tick
);
   import ictim_pkg::*;

   typedef enum {ST_IDLE, ST_SA, ST_SO, ST_DO, ST_SUM} ictim_state_e;

   ictim_state_e state;
   ictim_instr_s ins;
   logic [7:0] div_cnt;
   logic [CNT_W-1:0] clk_acc;
   logic [CNT_W-1:0] mem_acc;
   logic [1:0] rom_sel;
   logic [1:0] rom_t;
   logic rom_zero;
   logic [7:0] rom_inc;
   logic [7:0] mem_ns;
   // High in the cycle after ST_SUM, when the destination increment has landed.
   logic sum_q;

   // Widening add used for both counters.
   function automatic logic [CNT_W-1:0] acc_add(input logic [CNT_W-1:0] a,
                                                input logic [7:0] b);
      acc_add = a + {8'h00, b};
   endfunction : acc_add

   // clock enable divider
   // The instruction clock is a one-cycle enable derived from the core clock.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         div_cnt <= 8'h00;
         o_cpu_tick <= 1'b0;
      end else begin
         o_cpu_tick <= (div_cnt == CPU_DIV_M1);
         div_cnt <= (div_cnt == CPU_DIV_M1) ? 8'h00 : div_cnt + 8'h01;
      end
   end

   // Mode table lookup runs one state ahead of the accounting step.
   always_comb begin
      rom_sel = 2'h0;
      rom_t = ins.ts;
      rom_zero = ins.s_zero;
      case (state)
         ST_SO: begin
            rom_sel = 2'h1;
         end
         ST_DO: begin
            rom_sel = ins.do_mov ? 2'h3 : 2'h2;
            rom_t = ins.td;
            rom_zero = ins.d_zero;
         end
         default: begin
            rom_sel = 2'h0;
         end
      endcase
   end

   ictim_mode_rom u_rom (
      .i_core_clk(i_core_clk),
      .i_sel(rom_sel),
      .i_t(rom_t),
      .i_zero(rom_zero),
      .o_inc(rom_inc)
   );

   // memory cycle time
   // Only the module type and mapping option set the memory cycle length.
   always_comb begin
      mem_ns = i_ecc_mem ? 8'(MEM_ECC_NS / 5) : 8'(MEM_RAM_NS / 5);
      if (i_map_en) begin
         mem_ns = mem_ns + 8'(MAP_ADD_NS / 5);
      end
   end

   // Sequencer: capture, add each used increment, then total the time.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state <= ST_IDLE;
         ins <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (i_fetch) begin
                  ins <= i_instr;
                  state <= ST_SA;
               end
            end
            ST_SA: state <= ST_SO;
            ST_SO: state <= ST_DO;
            ST_DO: state <= ST_SUM;
            ST_SUM: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Cycle accumulators; the table result lags the state by one cycle.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         clk_acc <= '0;
         mem_acc <= '0;
      end else if (state == ST_IDLE && i_fetch) begin
         clk_acc <= '0;
         mem_acc <= '0;
         case (i_instr.op)
            ICTIM_OP_ABS: begin
               clk_acc <= {8'h00, ABS_CLK};
               mem_acc <= {8'h00, i_instr.src_neg ? ABS_NEG_MEM : ABS_POS_MEM};
            end
            ICTIM_OP_SER_OUT: begin
               clk_acc <= acc_add({8'h00, SOUT_CLK}, {3'h0, i_instr.bit_count});
               mem_acc <= {8'h00, SOUT_MEM};
            end
            ICTIM_OP_SER_IN: begin
               clk_acc <= acc_add({8'h00, (i_instr.bit_count <= SIN_SHORT_MAX) ?
                  SIN_SHORT_CLK : SIN_LONG_CLK}, {3'h0, i_instr.bit_count});
               mem_acc <= {8'h00, SIN_MEM};
            end
            ICTIM_OP_XOP: begin
               clk_acc <= i_instr.xop_hw ?
                  acc_add({8'h00, XOP_HW_CLK}, i_instr.xop_hw_clk) : {8'h00, XOP_SW_CLK};
               mem_acc <= {8'h00, i_instr.xop_hw ? XOP_HW_MEM : XOP_SW_MEM};
            end
            default: begin
               clk_acc <= {8'h00, i_instr.base_clk};
               mem_acc <= {8'h00, i_instr.base_mem};
            end
         endcase
      end else if (state == ST_SO && ins.use_sa || state == ST_DO && ins.use_so ||
                   state == ST_SUM && ins.use_do) begin
         clk_acc <= acc_add(clk_acc, {4'h0, rom_inc[7:4]});
         mem_acc <= acc_add(mem_acc, {4'h0, rom_inc[3:0]});
      end
   end

   // execution time
   // Publish the totals once the last increment has landed.
   // The destination increment is added on the ST_SUM edge, so publishing on that
   // same edge would drop it; the publish waits one more cycle instead.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_cost <= '0;
         o_done <= 1'b0;
         sum_q <= 1'b0;
      end else begin
         o_done <= 1'b0;
         sum_q <= (state == ST_SUM);
         if (sum_q) begin
            o_done <= 1'b1;
            o_cost.clk_cycles <= clk_acc;
            o_cost.mem_cycles <= mem_acc;
            o_cost.time_ns <= 32'(clk_acc) * 32'(CLK_PERIOD_NS) +
                              32'(mem_acc) * 32'(mem_ns) * 32'h5;
         end
      end
   end

   // Fetch accepted by the idle sequencer, the first step of every accounting walk.
   sequence fetch_taken_s;
      state == ST_IDLE && i_fetch;
   endsequence

   // An absolute-value fetch that uses no mode increment at all.
   sequence abs_fetch_s;
      fetch_taken_s ##0 (i_instr.op == ICTIM_OP_ABS && !i_instr.use_sa &&
         !i_instr.use_so && !i_instr.use_do);
   endsequence

   done_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_done |=> !o_done) else $error("done held more than one cycle");
   time_total_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_done && !i_map_en && !i_ecc_mem |-> o_cost.time_ns ==
      32'(o_cost.clk_cycles) * 32'(CLK_PERIOD_NS) + 32'(o_cost.mem_cycles) * 32'(MEM_RAM_NS))
      else $error("time total wrong");
   // absolute value counts
   // The result is seen six edges after the taking edge, one after the last increment.
   abs_cost_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      abs_fetch_s |-> ##6 o_done && o_cost.clk_cycles == {8'h00, ABS_CLK})
      else $error("abs cost wrong");
   tick_gap_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_cpu_tick |=> !o_cpu_tick [*8]) else $error("tick too frequent");
   acc_clear_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fetch_taken_s ##0 (i_instr.op == ICTIM_OP_GENERIC)
      |=> clk_acc == {8'h00, $past(i_instr.base_clk)} &&
      mem_acc == {8'h00, $past(i_instr.base_mem)})
      else $error("accumulators not restarted at fetch");
   ser_out_cost_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fetch_taken_s ##0 (i_instr.op == ICTIM_OP_SER_OUT)
      |=> clk_acc == {8'h00, SOUT_CLK} + {11'h000, $past(i_instr.bit_count)} &&
      mem_acc == {8'h00, SOUT_MEM})
      else $error("serial output base cost wrong");
   ser_in_cost_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fetch_taken_s ##0 (i_instr.op == ICTIM_OP_SER_IN && i_instr.bit_count > SIN_SHORT_MAX)
      |=> clk_acc == {8'h00, SIN_LONG_CLK} + {11'h000, $past(i_instr.bit_count)} &&
      mem_acc == {8'h00, SIN_MEM})
      else $error("serial input base cost wrong");
   xop_sw_cost_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
      fetch_taken_s ##0 (i_instr.op == ICTIM_OP_XOP && !i_instr.xop_hw)
      |=> clk_acc == {8'h00, XOP_SW_CLK} && mem_acc == {8'h00, XOP_SW_MEM})
      else $error("software extended operation cost wrong");
endmodule : ictim_top

// *** logic/ictim_pkg.sv ***
package ictim_pkg;
   // Clock periods and memory cycle times in nanoseconds.
   localparam int CLK_PERIOD_NS = 250;
   localparam int MEM_RAM_NS = 725;
   localparam int MEM_ECC_NS = 825;
   localparam int MAP_ADD_NS = 75;
   localparam int CORE_PERIOD_NS = 10;
   // Core cycles per instruction-processor clock.
   localparam int CPU_DIV = CLK_PERIOD_NS / CORE_PERIOD_NS;
   localparam logic [7:0] CPU_DIV_M1 = 8'(CPU_DIV - 1);
   localparam int CNT_W = 16;

   // Instruction classes that the timing model distinguishes.
   typedef enum logic [2:0] {
      ICTIM_OP_GENERIC,
      ICTIM_OP_ABS,
      ICTIM_OP_SER_OUT,
      ICTIM_OP_SER_IN,
      ICTIM_OP_XOP
   } ictim_op_e;

   // Base costs of the special instructions (clocks, memory cycles).
   localparam logic [7:0] ABS_CLK = 8'h05;
   localparam logic [7:0] ABS_POS_MEM = 8'h02;
   localparam logic [7:0] ABS_NEG_MEM = 8'h03;
   localparam logic [7:0] SOUT_CLK = 8'h04;
   localparam logic [7:0] SOUT_MEM = 8'h02;
   localparam logic [7:0] SIN_SHORT_CLK = 8'h12;
   localparam logic [7:0] SIN_LONG_CLK = 8'h18;
   localparam logic [7:0] SIN_MEM = 8'h03;
   localparam logic [4:0] SIN_SHORT_MAX = 5'h08;
   localparam logic [7:0] XOP_HW_CLK = 8'h03;
   localparam logic [7:0] XOP_HW_MEM = 8'h02;
   localparam logic [7:0] XOP_SW_CLK = 8'h07;
   localparam logic [7:0] XOP_SW_MEM = 8'h07;

   // One instruction's description as presented at fetch.
   typedef struct packed {
      ictim_op_e op;
      logic [7:0] base_clk;
      logic [7:0] base_mem;
      logic src_neg;
      logic [4:0] bit_count;
      logic xop_hw;
      logic [7:0] xop_hw_clk;
      logic use_sa;
      logic use_so;
      logic use_do;
      logic do_mov;
      logic [1:0] ts;
      logic s_zero;
      logic [1:0] td;
      logic d_zero;
   } ictim_instr_s;

   // Accounted cost of one instruction.
   typedef struct packed {
      logic [CNT_W-1:0] clk_cycles;
      logic [CNT_W-1:0] mem_cycles;
      logic [31:0] time_ns;
   } ictim_cost_s;
endpackage : ictim_pkg

// *** logic/ictim_mode_rom.sv ***
`timescale 1ns/1ps
// Address mode increment table, registered output.
module ictim_mode_rom (
   // Clock.
   input wire logic i_core_clk,
   // Lookup.
   input wire logic [1:0] i_sel,
   input wire logic [1:0] i_t,
   input wire logic i_zero,
   // Result: clocks in high nibble, memory cycles in low nibble.
   output logic [7:0] o_inc
);
   // Rows: 0 source address, 1 source operand, 2 destination, 3 destination of a move.
   logic [7:0] next_inc;

   always_comb begin
      next_inc = 8'h00;
      case ({i_sel, i_t})
         4'h0: next_inc = 8'h00;
         4'h1: next_inc = 8'h01;
         4'h2: next_inc = i_zero ? 8'h11 : 8'h32;
         4'h3: next_inc = 8'h12;
         4'h4: next_inc = 8'h01;
         4'h5: next_inc = 8'h02;
         4'h6: next_inc = i_zero ? 8'h12 : 8'h33;
         4'h7: next_inc = 8'h13;
         4'h8: next_inc = 8'h11;
         4'h9: next_inc = 8'h12;
         4'hA: next_inc = i_zero ? 8'h12 : 8'h33;
         4'hB: next_inc = 8'h23;
         4'hC: next_inc = 8'h20;
         4'hD: next_inc = 8'h21;
         4'hE: next_inc = i_zero ? 8'h21 : 8'h42;
         4'hF: next_inc = 8'h32;
         default: next_inc = 8'h00;
      endcase
   end

   // Registered so the read data comes out of a flip-flop.
   always_ff @(posedge i_core_clk) begin
      o_inc <= next_inc;
   end
endmodule : ictim_mode_rom

// *** verification/ictim_mem_model.sv ***
`timescale 1ns/1ps
// Memory modules fitted on the bus, seen as static straps.
module ictim_mem_model (
   // Chosen fit.
   input wire logic [1:0] i_cfg,
   // Straps and cycle time.
   output logic o_ecc_mem,
   output logic o_map_en,
   output int o_cyc_ns
);
   import ictim_pkg::*;
   always_comb begin
      o_ecc_mem = i_cfg[0];
      o_map_en = i_cfg[1];
      o_cyc_ns = (i_cfg[0] ? MEM_ECC_NS : MEM_RAM_NS) + (i_cfg[1] ? MAP_ADD_NS : 0);
   end
endmodule : ictim_mem_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
   import ictim_pkg::*;
   localparam int IW = $bits(ictim_instr_s);
   logic i_core_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_fetch = 1'b0;
   ictim_instr_s i_instr = '0;
   logic [1:0] cfg = 2'h0;
   logic ecc;
   logic map;
   int cyc_ns;
   ictim_cost_s o_cost;
   logic o_done;
   logic o_cpu_tick;
   int fail_count = 0;
   int num_checks = 0;
   // Mode increments as clk*10+mem: address, operand, destination, move.
   int inc [4][5] = '{'{0, 1, 11, 32, 12}, '{1, 2, 12, 33, 13}, '{11, 12, 12, 33, 23},
      '{20, 21, 21, 42, 32}};

   ictim_mem_model u_ictim_mem_model (.i_cfg(cfg), .o_ecc_mem(ecc), .o_map_en(map),
      .o_cyc_ns(cyc_ns));
   ictim_top u_ictim_top (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_fetch(i_fetch),
      .i_instr(i_instr), .i_ecc_mem(ecc), .i_map_en(map), .o_cost(o_cost),
      .o_done(o_done), .o_cpu_tick(o_cpu_tick));

   // Free running core clock.
   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   function automatic int ix(input logic [1:0] t, input logic z);
      return (t == 2'h3) ? 4 : (t == 2'h2) ? (z ? 2 : 3) : int'(t);
   endfunction : ix

   // Reference cost, clocks returned and memory cycles in m.
   function automatic int expc(input ictim_instr_s x, output int m);
      int c;
      int a;
      c = x.base_clk;
      m = x.base_mem;
      if (x.op == ICTIM_OP_ABS) begin
         c = 5;
         m = x.src_neg ? 3 : 2;
      end
      if (x.op == ICTIM_OP_SER_OUT) begin
         c = 4 + x.bit_count;
         m = 2;
      end
      if (x.op == ICTIM_OP_SER_IN) begin
         c = (x.bit_count > 8 ? 24 : 18) + x.bit_count;
         m = 3;
      end
      if (x.op == ICTIM_OP_XOP) begin
         c = x.xop_hw ? 3 + x.xop_hw_clk : 7;
         m = x.xop_hw ? 2 : 7;
      end
      a = x.use_sa ? inc[0][ix(x.ts, x.s_zero)] : 0;
      a += x.use_so ? inc[1][ix(x.ts, x.s_zero)] : 0;
      a += x.use_do ? inc[x.do_mov ? 3 : 2][ix(x.td, x.d_zero)] : 0;
      m += a % 10;
      return c + a / 10;
   endfunction : expc

   // One instruction; junk adds a fetch in mid-run that must be ignored.
   task automatic run_op(input ictim_instr_s x, input logic junk, input logic [1:0] cf);
      int c;
      int m;
      int n;
      c = expc(x, m);
      @(posedge i_core_clk);
      i_fetch <= 1'b1;
      i_instr <= x;
      cfg <= cf;
      for (n = 0; n < 9; n++) begin
         @(posedge i_core_clk);
         i_fetch <= junk && n == 2;
         if (n == 2) i_instr <= ictim_instr_s'(~x);
         #1;
         if (o_done === 1'b1) break;
      end
      chk(n, 5);
      if (n == 9) complete_run();
      chk(o_cost.clk_cycles, c);
      chk(o_cost.mem_cycles, m);
      chk(o_cost.time_ns, c * CLK_PERIOD_NS + m * cyc_ns);
   endtask : run_op

   task automatic tick_gap;
      int n;
      int k;
      for (k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge i_core_clk);
            #1;
            n++;
         end while (o_cpu_tick !== 1'b1 && n < 60);
         // A tick that never comes ends the run as a failure.
         if (o_cpu_tick !== 1'b1) begin
            chk(n, CPU_DIV);
            complete_run();
         end
      end
      chk(n, CPU_DIV);
   endtask : tick_gap

   // Main sequence: reset, clock tick, then every class in every memory fit.
   initial begin
      int i;
      ictim_instr_s x;
      void'($urandom(32'h6E588F34));
      repeat (6) @(posedge i_core_clk);
      i_srst <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk(o_done, 0);
      chk(o_cost.time_ns, 0);
      tick_gap();
      $display("test tick done");
      for (i = 0; i < 60; i++) begin
         x = ictim_instr_s'(IW'({$urandom, $urandom}));
         x.op = ictim_op_e'(i % 5);
         x.bit_count = 5'($urandom_range(16, 1));
         if (x.op == ICTIM_OP_ABS) begin
            x.use_sa = i[4];
            x.use_so = 1'b0;
            x.use_do = 1'b0;
         end
         if (i < 20) begin
            x.src_neg = i[3];
            x.xop_hw = i[2];
            x.bit_count = i[3] ? 5'h09 : 5'h08;
         end
         run_op(x, i[1], 2'(i / 5));
      end
      $display("test costs done");
      complete_run();
   end
endmodule : tb
